// file: verilog/hcf_top.sv
`timescale 1ns/100ps
`include "hcf_regs.svh"
// How it works
// - Pipeline overflow raises a sticky flag; device does not repair dataflow.
// - A command written while flag is zero never stalls execution.
// - Demand DMA counts words remaining in the current transfer.
// - Start input at load <= lower limit, output at load >= upper limit.
// - Transfer amount comes from live FIFO load at request time.
// - A zero-word transfer finishes at once; later transfers still start.
module hcf_top
   import hcf_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic [`HCF_ADDR_W-1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic cmd_wr_in,
   input wire logic cmd_done_in,
   input wire logic [7:0] in_fifo_load_in,
   input wire logic [7:0] out_fifo_load_in,
   input wire logic dma_ack_in,
   output hcf_pkg::hcf_dma_pins_t dma_out,
   output logic irq_out
);
   import hcf_pkg::*;

   logic [1:0] ctrl_reg, ctrl_next;
   logic [2:0] ists_reg, ists_next;
   logic [2:0] imask_reg, imask_next;
   logic [7:0] in_ll_reg, in_ll_next;
   logic [7:0] out_ul_reg, out_ul_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] rem_reg, rem_next;
   logic [7:0] in_rem_reg, in_rem_next;
   logic [7:0] out_rem_reg, out_rem_next;
   hcf_dma_state_t st_reg, st_next;
   logic ack_s1_reg, ack_s2_reg;
   logic cwen, ovf_pulse;
   logic in_done, out_done;
   logic sel_wr;

   // Width-safe register field write
   function automatic logic [7:0] lo8(input logic [31:0] d);
      lo8 = d[7:0];
   endfunction

   hcf_cmd_ctrl hcf_cmd_ctrl_inst (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .cmd_wr_in(cmd_wr_in),
      .cmd_done_in(cmd_done_in),
      .cwen_out(cwen),
      .overflow_out(ovf_pulse)
   );

   // Acknowledge pin synchroniser
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end else begin
         ack_s1_reg <= dma_ack_in;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   // Demand-mode DMA sequencer
   always_comb begin
      st_next = st_reg;
      rem_next = rem_reg;
      in_done = 1'b0;
      out_done = 1'b0;
      case (st_reg)
         HCF_IDLE: begin
            if (ctrl_reg[`HCF_CTRL_IN_EN] &&
                in_fifo_load_in <= in_ll_reg) begin
               // Size from live load, not the limit
               rem_next = `HCF_FIFO_DEPTH - in_fifo_load_in;
               if (rem_next == 8'h00)
                  in_done = 1'b1;
               else
                  st_next = HCF_IN;
            end else if (ctrl_reg[`HCF_CTRL_OUT_EN] &&
                         out_fifo_load_in >= out_ul_reg) begin
               rem_next = out_fifo_load_in;
               if (rem_next == 8'h00)
                  out_done = 1'b1;
               else
                  st_next = HCF_OUT;
            end
         end
         HCF_IN, HCF_OUT: begin
            if (ack_s2_reg) begin
               rem_next = rem_reg - 8'h01;
               if (rem_reg == 8'h01) begin
                  st_next = HCF_IDLE;
                  in_done = (st_reg == HCF_IN);
                  out_done = (st_reg == HCF_OUT);
               end
            end
         end
         default: st_next = HCF_IDLE;
      endcase
   end

   // Remaining-word views per direction
   always_comb begin
      in_rem_next = (st_next == HCF_IN) ? rem_next : 8'h00;
      out_rem_next = (st_next == HCF_OUT) ? rem_next : 8'h00;
   end

   // Register writes; set beats write-one-to-clear
   always_comb begin
      sel_wr = wr_in;
      ctrl_next = ctrl_reg;
      imask_next = imask_reg;
      in_ll_next = in_ll_reg;
      out_ul_next = out_ul_reg;
      ists_next = ists_reg;
      if (sel_wr) begin
         case (addr_in)
            `HCF_OFF_CTRL: ctrl_next = wdata_in[1:0];
            `HCF_OFF_IRQ_MASK: imask_next = wdata_in[2:0];
            `HCF_OFF_IN_LL: in_ll_next = lo8(wdata_in);
            `HCF_OFF_OUT_UL: out_ul_next = lo8(wdata_in);
            `HCF_OFF_IRQ_STAT: ists_next = ists_reg & ~wdata_in[2:0];
            default: ;
         endcase
      end
      if (ovf_pulse)
         ists_next[`HCF_IRQ_EOV] = 1'b1;
      if (in_done)
         ists_next[`HCF_IRQ_IN_DONE] = 1'b1;
      if (out_done)
         ists_next[`HCF_IRQ_OUT_DONE] = 1'b1;
   end

   // Read data, valid the cycle after the strobe
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (rd_in) begin
         case (addr_in)
            `HCF_OFF_CTRL: rdata_next = {30'h0, ctrl_reg};
            `HCF_OFF_STAT: rdata_next = {28'h0, st_reg == HCF_OUT,
               st_reg == HCF_IN, ists_reg[`HCF_IRQ_EOV], cwen};
            `HCF_OFF_IRQ_STAT: rdata_next = {29'h0, ists_reg};
            `HCF_OFF_IRQ_MASK: rdata_next = {29'h0, imask_reg};
            `HCF_OFF_IN_LL: rdata_next = {24'h0, in_ll_reg};
            `HCF_OFF_OUT_UL: rdata_next = {24'h0, out_ul_reg};
            `HCF_OFF_IN_REM: rdata_next = {24'h0, in_rem_reg};
            `HCF_OFF_OUT_REM: rdata_next = {24'h0, out_rem_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // State registers
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= HCF_IDLE;
         rem_reg <= 8'h00;
         in_rem_reg <= 8'h00;
         out_rem_reg <= 8'h00;
         ctrl_reg <= 2'h0;
         ists_reg <= 3'h0;
         imask_reg <= 3'h0;
         in_ll_reg <= `HCF_RST_IN_LL;
         out_ul_reg <= `HCF_RST_OUT_UL;
         rdata_reg <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
         rem_reg <= rem_next;
         in_rem_reg <= in_rem_next;
         out_rem_reg <= out_rem_next;
         ctrl_reg <= ctrl_next;
         ists_reg <= ists_next;
         imask_reg <= imask_next;
         in_ll_reg <= in_ll_next;
         out_ul_reg <= out_ul_next;
         rdata_reg <= rdata_next;
      end
   end

   // Outputs
   assign rdata_out = rdata_reg;
   assign dma_out.req = (st_reg == HCF_IN) || (st_reg == HCF_OUT);
   assign dma_out.ack = ack_s2_reg;
   assign dma_out.dir_out = (st_reg == HCF_OUT);
   assign irq_out = |(ists_reg & imask_reg);
endmodule // hcf_top

// file: verilog/hcf_regs.svh
`ifndef HCF_REGS_SVH
`define HCF_REGS_SVH
// Register offsets (word addresses on the plain port)
`define HCF_ADDR_W 4
`define HCF_OFF_CTRL 4'h0
`define HCF_OFF_STAT 4'h1
`define HCF_OFF_IRQ_STAT 4'h2
`define HCF_OFF_IRQ_MASK 4'h3
`define HCF_OFF_IN_LL 4'h4
`define HCF_OFF_OUT_UL 4'h5
`define HCF_OFF_IN_REM 4'h6
`define HCF_OFF_OUT_REM 4'h7
// Control fields
`define HCF_CTRL_IN_EN 0
`define HCF_CTRL_OUT_EN 1
// Status fields
`define HCF_STAT_CWEN 0
`define HCF_STAT_EOV 1
`define HCF_STAT_IN_BUSY 2
`define HCF_STAT_OUT_BUSY 3
// Interrupt fields
`define HCF_IRQ_EOV 0
`define HCF_IRQ_IN_DONE 1
`define HCF_IRQ_OUT_DONE 2
// Sizes and reset values
`define HCF_FIFO_DEPTH 8'h80
`define HCF_CMD_DEPTH 4'h8
`define HCF_RST_IN_LL 8'h40
`define HCF_RST_OUT_UL 8'h40
`endif

// file: verilog/hcf_pkg.sv
package hcf_pkg;
   typedef enum logic [2:0] {
      HCF_IDLE = 3'b001,
      HCF_IN = 3'b010,
      HCF_OUT = 3'b100
   } hcf_dma_state_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } hcf_bus_req_t;
   typedef struct packed {
      logic req;
      logic ack;
      logic dir_out;
   } hcf_dma_pins_t;
endpackage

// file: verilog/hcf_cmd_ctrl.sv
`timescale 1ns/100ps
`include "hcf_regs.svh"
// Command pipeline occupancy and write-enable flag
module hcf_cmd_ctrl
   import hcf_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic cmd_wr_in,
   input wire logic cmd_done_in,
   output logic cwen_out,
   output logic overflow_out
);
   logic [3:0] count_reg, count_next;
   logic ovf_reg, ovf_next;

   // Count accepted commands; a write into a full pipe is dropped
   always_comb begin
      count_next = count_reg;
      ovf_next = 1'b0;
      if (cmd_wr_in && count_reg == `HCF_CMD_DEPTH) begin
         ovf_next = 1'b1;
         if (cmd_done_in)
            count_next = count_reg - 4'h1;
      end else if (cmd_wr_in && !cmd_done_in) begin
         count_next = count_reg + 4'h1;
      end else if (!cmd_wr_in && cmd_done_in && count_reg != 4'h0) begin
         count_next = count_reg - 4'h1;
      end
   end

   // Registers
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count_reg <= 4'h0;
         ovf_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         ovf_reg <= ovf_next;
      end
   end

   // Dropping the excess command keeps execution running
   assign cwen_out = (count_reg != `HCF_CMD_DEPTH);
   assign overflow_out = ovf_reg;
endmodule // hcf_cmd_ctrl

// file: dv/hcf_props.sv
`timescale 1ns/100ps
// Port-level checks of the flow control block
module hcf_props
   import hcf_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic [3:0] addr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic [7:0] in_fifo_load_in,
   input wire logic [7:0] out_fifo_load_in,
   input wire logic dma_ack_in,
   input wire hcf_pkg::hcf_dma_pins_t dma_out,
   input wire logic irq_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!nrst_in);
   // Read data only in the cycle after a read strobe
   a_rdata_idle_zero:
      assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data not zero outside read");
   a_unmapped_read: assert property ($past(rd_in) && $past(addr_in[3])
      |-> rdata_out == 32'h0) else $error("unmapped read not zero");
   // Word handshake and transfer length
   a_ack_sync_delay:
      assert property (dma_out.ack == $past(dma_ack_in, 2))
      else $error("ack not two cycles behind pin");
   a_req_end_acked:
      assert property ($fell(dma_out.req) |-> $past(dma_out.ack))
      else $error("request ended without counted word");
   a_req_min_len:
      assert property ($rose(dma_out.req) |-> dma_out.req[*3])
      else $error("request shorter than one word");
   a_dir_held:
      assert property (dma_out.req && $past(dma_out.req)
      |-> $stable(dma_out.dir_out)) else $error("direction changed");
   // A zero amount never raises a request
   a_in_nonzero:
      assert property ($rose(dma_out.req) && !dma_out.dir_out
      |-> $past(in_fifo_load_in) != 8'h80)
      else $error("input request with zero amount");
   a_out_nonzero:
      assert property ($rose(dma_out.req) && dma_out.dir_out
      |-> $past(out_fifo_load_in) != 8'h00)
      else $error("output request with zero amount");
   c_in_start: cover property ($rose(dma_out.req) && !dma_out.dir_out);
   c_out_start: cover property ($rose(dma_out.req) && dma_out.dir_out);
   c_irq: cover property ($rose(irq_out));
endmodule // hcf_props

// file: dv/hcf_host_model.sv
`timescale 1ns/100ps
// Host side of the demand handshake, one word per ack cycle
module hcf_host_model
   import hcf_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire hcf_pkg::hcf_dma_pins_t dma_out,
   input wire logic slow_in,
   output logic dma_ack_in
);
   logic ack_next;
   // Slow mode acks every other cycle, never unless req was high the cycle before
   always_comb begin
      ack_next = dma_out.req && (!slow_in || !dma_ack_in);
   end
   // Ack pin register
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dma_ack_in <= 1'b0;
      end else begin
         dma_ack_in <= ack_next;
      end
   end
endmodule // hcf_host_model

// file: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import hcf_pkg::*;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [31:0] rdata_out;
   logic cmd_wr_in = 1'b0;
   logic cmd_done_in = 1'b0;
   logic [7:0] in_fifo_load_in = 8'h0;
   logic [7:0] out_fifo_load_in = 8'h0;
   logic dma_ack_in;
   logic slow_in = 1'b0;
   logic irq_out;
   hcf_dma_pins_t dma_out;
   int n_errors = 0;
   int compares = 0;
   // Reset values: address beside expected read data
   localparam logic [35:0] ROWS [9] = '{36'h0, 36'h100000001,
      36'h200000000, 36'h300000000, 36'h400000040, 36'h500000040,
      36'h600000000, 36'h700000000, 36'h800000000};
   hcf_top hcf_top_inst (.*);
   hcf_host_model hcf_host_model_inst (.*);
   // Clock
   initial begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   task tk;
      @(posedge sys_clk_in);
   endtask
   task summarize;
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      tk();
      wr_in <= 1'b0;
      tk();
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      rd_in <= 1'b1;
      addr_in <= a;
      tk();
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, e);
      tk();
   endtask
   // Bounded wait for the request level
   task wt(input logic v);
      int i;
      i = 0;
      while (dma_out.req !== v) begin
         @(negedge sys_clk_in);
         i++;
         if (i > 300) begin
            n_errors++;
            summarize();
         end
      end
      tk();
   endtask
   // Main sequence
   initial begin
      repeat (8) tk();
      nrst_in <= 1'b1;
      tk();
      foreach (ROWS[k]) rd(ROWS[k][35:32], ROWS[k][31:0]);
      // Host polls the write enable flag before its command burst
      rd(4'h1, 32'h1);
      cmd_wr_in <= 1'b1;
      repeat (8) tk();
      cmd_wr_in <= 1'b0;
      tk();
      rd(4'h1, 32'h0);
      cmd_wr_in <= 1'b1;
      tk();
      cmd_wr_in <= 1'b0;
      repeat (2) tk();
      rd(4'h2, 32'h1);
      wr(4'h3, 32'h7);
      rd(4'h1, 32'h2);
      chk(irq_out, 1'b1);
      wr(4'h2, 32'h1);
      rd(4'h2, 32'h0);
      chk(irq_out, 1'b0);
      cmd_done_in <= 1'b1;
      tk();
      cmd_done_in <= 1'b0;
      tk();
      rd(4'h1, 32'h1);
      wr(4'h4, 32'h80);
      in_fifo_load_in <= 8'h80;
      wr(4'h0, 32'h1);
      repeat (3) tk();
      chk(dma_out.req, 1'b0);
      rd(4'h2, 32'h2);
      // Back to a legal lower limit before a real transfer
      wr(4'h4, 32'h7f);
      in_fifo_load_in <= 8'h7d;
      wt(1'b1);
      in_fifo_load_in <= 8'h81;
      rd(4'h6, 32'h3);
      chk(dma_out.dir_out, 1'b0);
      wt(1'b0);
      rd(4'h6, 32'h0);
      wr(4'h2, 32'h7);
      wr(4'h5, 32'h0);
      wr(4'h0, 32'h2);
      repeat (3) tk();
      rd(4'h2, 32'h4);
      // Back to a legal upper limit before a real transfer
      wr(4'h5, 32'h2);
      slow_in <= 1'b1;
      out_fifo_load_in <= 8'h2;
      wt(1'b1);
      out_fifo_load_in <= 8'h0;
      rd(4'h7, 32'h2);
      chk(dma_out.dir_out, 1'b1);
      wt(1'b0);
      // Reset after the output transfer ends returns every register to its reset value
      nrst_in <= 1'b0;
      repeat (2) tk();
      chk(dma_out, 3'h0);
      chk(irq_out, 1'b0);
      nrst_in <= 1'b1;
      tk();
      foreach (ROWS[k]) rd(ROWS[k][35:32], ROWS[k][31:0]);
      summarize();
   end
endmodule // tb_top
bind hcf_top hcf_props hcf_props_inst (.*);
